//--- hbfm_map.svh
// Constants of the half-bridge fault manager: bit positions, codes and timing
`ifndef HBFM_MAP_SVH
`define HBFM_MAP_SVH

// Number of half-bridges
`define HBFM_BRIDGES        6

// Command word field positions (serial input)
`define HBFM_IN_SRR         15
`define HBFM_IN_UNDERLOAD_SHUTDOWN_CTRL       13
`define HBFM_IN_EN_HI       12
`define HBFM_IN_EN_LO       7
`define HBFM_IN_CNF_HI      6
`define HBFM_IN_CNF_LO      1
`define HBFM_IN_OVERVOLTAGE_LOCKOUT_CTRL        0

// Status word field positions (serial output)
`define HBFM_OUT_OC         15
`define HBFM_OUT_PSF        14
`define HBFM_OUT_ULD        13
`define HBFM_OUT_CODE_LO    1
`define HBFM_OUT_TW         0

// Per-bridge two-bit status codes
`define HBFM_CODE_OK        2'h0
`define HBFM_CODE_OC        2'h1
`define HBFM_CODE_UL        2'h2
`define HBFM_CODE_TSD       2'h3

// Serial frame shape
`define HBFM_FRAME_FIRST    16
`define HBFM_FRAME_STEP_LSB 3
`define HBFM_WORD_W         16
`define HBFM_BITCNT_W       9

// Reset values
`define HBFM_WORD_RST       16'h0000
`define HBFM_SYNC_RST       1'b0

// Timing: clock period and fault delays in ns, counts rounded up
`define HBFM_CLK_PERIOD_NS  40
`define HBFM_OC_DELAY_NS    10000
`define HBFM_UL_DELAY_NS    200000
`define HBFM_OC_DELAY_CYC   ((`HBFM_OC_DELAY_NS + `HBFM_CLK_PERIOD_NS - 1) / `HBFM_CLK_PERIOD_NS)
`define HBFM_UL_DELAY_CYC   ((`HBFM_UL_DELAY_NS + `HBFM_CLK_PERIOD_NS - 1) / `HBFM_CLK_PERIOD_NS)

`endif

//--- hbfm_pkg.sv
// Shared types of the half-bridge fault manager
`default_nettype none
`include "hbfm_map.svh"

package hbfm_pkg;

    // One bit per half-bridge
    typedef logic [`HBFM_BRIDGES-1:0] hbfm_bridges_t;

    // Serial word, in or out
    typedef logic [`HBFM_WORD_W-1:0] hbfm_word_t;

    // Per-bridge status code
    typedef logic [1:0] hbfm_code_t;

endpackage

`default_nettype wire

//--- hbfm_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous inputs
`default_nettype none
`include "hbfm_map.svh"

module hbfm_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] out;
    } hbfm_sync_st_t;

    hbfm_sync_st_t q;
    hbfm_sync_st_t d;

    // Stage one feeds only stage two; output moves when stages two and three agree
    always_comb
    begin
        d     = q;
        d.s1  = async_i;
        d.s2  = q.s1;
        d.s3  = q.s2;
        d.out = (q.s2 & q.s3) | (q.out & (q.s2 ^ q.s3));
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            q <= {(4*W){`HBFM_SYNC_RST}};
        else
            q <= d;
    end

    assign sync_o = q.out;

endmodule

`default_nettype wire

//--- hbfm_spi.sv
// Serial slave: status shift-out, command capture and frame length check
`default_nettype none
`include "hbfm_map.svh"

module hbfm_spi (
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    input  wire logic               clr_i,
    input  wire logic               sclk_i,
    input  wire logic               cs_n_i,
    input  wire logic               si_i,
    input  wire hbfm_pkg::hbfm_word_t status_i,
    input  wire logic               tsd_i,
    output var hbfm_pkg::hbfm_word_t cmd_o,
    output logic                    cmd_valid_o,
    output logic                    so_o,
    output logic                    so_oe_o
);

    typedef struct packed {
        logic                      sclk_p;
        logic                      cs_p;
        logic                      active;
        logic                      first;
        logic [`HBFM_BITCNT_W-1:0] cnt;
        logic                      ovf;
        hbfm_pkg::hbfm_word_t      shreg;
        hbfm_pkg::hbfm_word_t      cmd;
        logic                      cmd_v;
        logic                      so;
        logic                      so_oe;
    } hbfm_spi_st_t;

    hbfm_spi_st_t q;
    hbfm_spi_st_t d;

    // Sixteen bits, then whole bytes; overflowed counts are never valid
    function automatic logic frame_ok(input logic [`HBFM_BITCNT_W-1:0] n, input logic ovf);
        frame_ok = !ovf && (n >= `HBFM_BITCNT_W'(`HBFM_FRAME_FIRST))
                   && (n[`HBFM_FRAME_STEP_LSB-1:0] == '0);
    endfunction

    // Data leaves on rising clock, enters on falling clock
    always_comb
    begin
        d        = q;
        d.sclk_p = sclk_i;
        d.cs_p   = cs_n_i;
        d.cmd_v  = 1'b0;
        if (!cs_n_i && q.cs_p)
        begin
            d.shreg  = status_i;
            d.first  = 1'b1;
            d.cnt    = '0;
            d.ovf    = 1'b0;
            d.active = 1'b1;
            d.so     = tsd_i;
            d.so_oe  = 1'b1;
        end
        else if (q.active && !cs_n_i)
        begin
            if (sclk_i && !q.sclk_p)
            begin
                d.so    = q.shreg[`HBFM_WORD_W-1];
                d.first = 1'b0;
            end
            if (!sclk_i && q.sclk_p && !q.first)
            begin
                d.shreg = {q.shreg[`HBFM_WORD_W-2:0], si_i};
                d.cnt   = q.cnt + `HBFM_BITCNT_W'(1);
                d.ovf   = q.ovf | (&q.cnt);
            end
        end
        else if (q.active && cs_n_i)
        begin
            // Short or ragged frames vanish without trace
            d.active = 1'b0;
            d.so     = 1'b0;
            d.so_oe  = 1'b0;
            if (frame_ok(q.cnt, q.ovf))
            begin
                d.cmd   = q.shreg;
                d.cmd_v = 1'b1;
            end
        end
        if (clr_i)
            d = '0;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            q <= '0;
        else
            q <= d;
    end

    assign cmd_o       = q.cmd;
    assign cmd_valid_o = q.cmd_v;
    assign so_o        = q.so;
    assign so_oe_o     = q.so_oe;

endmodule

`default_nettype wire

//--- hbfm_top.sv
// Fault manager of a six-channel half-bridge driver with serial control
`default_nettype none
`include "hbfm_map.svh"

module hbfm_top #(
    parameter int unsigned OC_DELAY_CYC = `HBFM_OC_DELAY_CYC,
    parameter int unsigned UL_DELAY_CYC = `HBFM_UL_DELAY_CYC,
    parameter int unsigned OC_CNT_W     = 16,
    parameter int unsigned UL_CNT_W     = 24
) (
    input  wire logic                          CLK_I,
    input  wire logic                          RESETN_I,
    input  wire logic                          EN_I,
    input  wire logic                          SCLK_I,
    input  wire logic                          CS_N_I,
    input  wire logic                          SI_I,
    output logic                               SO_O,
    output logic                               SO_OE_O,
    input  wire logic                          MOTOR_SUPPLY_A_OV_I,
    input  wire logic                          MOTOR_SUPPLY_B_OV_I,
    input  wire logic                          MOTOR_SUPPLY_UV_I,
    input  wire logic [`HBFM_BRIDGES-1:0]      HIGH_SIDE_SWITCH_OC_I,
    input  wire logic [`HBFM_BRIDGES-1:0]      LOW_SIDE_SWITCH_OC_I,
    input  wire logic [`HBFM_BRIDGES-1:0]      UNDERLOAD_CURRENT_LIMIT_I,
    input  wire logic [`HBFM_BRIDGES-1:0]      TEMP_WARN_I,
    input  wire logic [`HBFM_BRIDGES-1:0]      TEMP_SHUTDOWN_I,
    output logic      [`HBFM_BRIDGES-1:0]      HIGH_SIDE_SWITCH_ON_O,
    output logic      [`HBFM_BRIDGES-1:0]      LOW_SIDE_SWITCH_ON_O
);

    localparam int unsigned NB     = `HBFM_BRIDGES;
    localparam int unsigned SYNC_W = 3 + 3 + 5 * NB + 1;

    localparam logic [OC_CNT_W-1:0] OC_LAST = OC_CNT_W'(OC_DELAY_CYC - 1);
    localparam logic [UL_CNT_W-1:0] UL_LAST = UL_CNT_W'(UL_DELAY_CYC - 1);

    // Complete state of the fault manager
    typedef struct packed {
        hbfm_pkg::hbfm_bridges_t         bridge_on_bit;
        hbfm_pkg::hbfm_bridges_t         bridge_polarity_bit;
        logic                            overvoltage_lockout_ctrl;
        logic                            underload_shutdown_ctrl;
        hbfm_pkg::hbfm_bridges_t         oc_seen;
        hbfm_pkg::hbfm_bridges_t         ul_seen;
        hbfm_pkg::hbfm_bridges_t         tsd_seen;
        hbfm_pkg::hbfm_bridges_t         latched_off;
        logic [NB-1:0][OC_CNT_W-1:0]     oc_cnt;
        logic [UL_CNT_W-1:0]             ul_cnt;
        hbfm_pkg::hbfm_bridges_t         hs_on;
        hbfm_pkg::hbfm_bridges_t         ls_on;
    } hbfm_st_t;

    hbfm_st_t q;
    hbfm_st_t d;

    // Synchronised inputs
    logic [SYNC_W-1:0]       sync_in;
    logic [SYNC_W-1:0]       sync_out;
    logic                    en_s;
    logic                    sclk_s;
    logic                    cs_n_s;
    logic                    si_s;
    logic                    ov_a_s;
    logic                    ov_b_s;
    logic                    uv_s;
    hbfm_pkg::hbfm_bridges_t oc_hs_s;
    hbfm_pkg::hbfm_bridges_t oc_ls_s;
    hbfm_pkg::hbfm_bridges_t ul_s;
    hbfm_pkg::hbfm_bridges_t tw_s;
    hbfm_pkg::hbfm_bridges_t tsd_s;

    // Serial side
    hbfm_pkg::hbfm_word_t    cmd;
    logic                    cmd_valid;
    hbfm_pkg::hbfm_word_t    status_word;

    // Fault decode, shared between the state update and the status word
    logic                    supply_fail_flag;
    logic                    lockout;
    logic                    thermal_warning_flag;
    logic                    overcurrent_flag;
    logic                    underload_flag;
    logic                    tsd_flag;
    hbfm_pkg::hbfm_bridges_t driving;
    hbfm_pkg::hbfm_bridges_t oc_cond;
    hbfm_pkg::hbfm_bridges_t oc_trip;
    hbfm_pkg::hbfm_bridges_t ul_cond;
    hbfm_pkg::hbfm_bridges_t ul_hit;
    hbfm_pkg::hbfm_bridges_t latch_now;
    logic                    ul_expired;

    // Priority: over-current first, then thermal shutdown, then under-load
    function automatic hbfm_pkg::hbfm_code_t code_of(input logic oc, input logic ul, input logic tsd);
        if (oc)
            code_of = `HBFM_CODE_OC;
        else if (tsd)
            code_of = `HBFM_CODE_TSD;
        else if (ul)
            code_of = `HBFM_CODE_UL;
        else
            code_of = `HBFM_CODE_OK;
    endfunction

    // Every pin except clock and reset, and every comparator, crosses into the clock domain here
    assign sync_in = {EN_I, SCLK_I, CS_N_I, SI_I,
                      MOTOR_SUPPLY_A_OV_I, MOTOR_SUPPLY_B_OV_I, MOTOR_SUPPLY_UV_I,
                      HIGH_SIDE_SWITCH_OC_I, LOW_SIDE_SWITCH_OC_I, UNDERLOAD_CURRENT_LIMIT_I,
                      TEMP_WARN_I, TEMP_SHUTDOWN_I};

    hbfm_sync #(
        .W       (SYNC_W)
    ) u_sync (
        .clk_i   (CLK_I),
        .rst_n_i (RESETN_I),
        .async_i (sync_in),
        .sync_o  (sync_out)
    );

    assign {en_s, sclk_s, cs_n_s, si_s, ov_a_s, ov_b_s, uv_s,
            oc_hs_s, oc_ls_s, ul_s, tw_s, tsd_s} = sync_out;

    // Serial slave; held cleared while the enable pin is low
    hbfm_spi u_spi (
        .clk_i       (CLK_I),
        .rst_n_i     (RESETN_I),
        .clr_i       (!en_s),
        .sclk_i      (sclk_s),
        .cs_n_i      (cs_n_s),
        .si_i        (si_s),
        .status_i    (status_word),
        .tsd_i       (tsd_flag),
        .cmd_o       (cmd),
        .cmd_valid_o (cmd_valid),
        .so_o        (SO_O),
        .so_oe_o     (SO_OE_O)
    );

    // Supply monitoring: over-voltage flag is pure level, never latched
    always_comb
    begin
        supply_fail_flag = ov_a_s | ov_b_s | uv_s;
        lockout          = uv_s | (q.overvoltage_lockout_ctrl & (ov_a_s | ov_b_s));
    end

    // Global flags are the OR of the per-bridge memories, except thermal warning, the OR of the live synchronised inputs
    always_comb
    begin
        thermal_warning_flag = |tw_s;
        overcurrent_flag     = |q.oc_seen;
        underload_flag       = |q.ul_seen;
        tsd_flag             = |q.tsd_seen;
    end

    // Status word captured by the serial slave when a frame opens
    always_comb
    begin
        status_word                    = `HBFM_WORD_RST;
        status_word[`HBFM_OUT_OC]      = overcurrent_flag;
        status_word[`HBFM_OUT_PSF]     = supply_fail_flag;
        status_word[`HBFM_OUT_ULD]     = underload_flag;
        status_word[`HBFM_OUT_TW]      = thermal_warning_flag;
        for (int i = 0; i < NB; i++)
        begin
            status_word[`HBFM_OUT_CODE_LO + 2*i +: 2] =
                code_of(q.oc_seen[i], q.ul_seen[i], q.tsd_seen[i]);
        end
    end

    // Current monitoring only looks at bridges actually being driven
    always_comb
    begin
        driving = q.bridge_on_bit & {NB{!lockout}};
        for (int i = 0; i < NB; i++)
        begin
            oc_cond[i] = driving[i] & ((q.bridge_polarity_bit[i] & oc_hs_s[i])
                                     | (!q.bridge_polarity_bit[i] & oc_ls_s[i]));
            oc_trip[i] = oc_cond[i] && (q.oc_cnt[i] == OC_LAST);
            ul_cond[i] = driving[i] & !q.bridge_polarity_bit[i] & ul_s[i];
        end
        // Shared timer: once it has run out, any bridge under load is hit at once
        ul_expired = (|ul_cond) && (q.ul_cnt == UL_LAST);
        ul_hit     = ul_cond & {NB{ul_expired}};
        latch_now  = oc_trip | tsd_s
                   | (ul_hit & {NB{q.underload_shutdown_ctrl}});
    end

    // State update: frame effects first, then fault sets, so a set beats a clear
    always_comb
    begin
        d = q;

        // Per-bridge over-current delay counters restart when current drops
        for (int i = 0; i < NB; i++)
        begin
            if (!oc_cond[i])
                d.oc_cnt[i] = '0;
            else if (q.oc_cnt[i] != OC_LAST)
                d.oc_cnt[i] = q.oc_cnt[i] + OC_CNT_W'(1);
        end

        // One under-load timer runs while any bridge is under load
        if (!(|ul_cond))
            d.ul_cnt = '0;
        else if (q.ul_cnt != UL_LAST)
            d.ul_cnt = q.ul_cnt + UL_CNT_W'(1);

        // Valid frames program the bridges and may clear latched faults
        if (cmd_valid)
        begin
            d.overvoltage_lockout_ctrl = cmd[`HBFM_IN_OVERVOLTAGE_LOCKOUT_CTRL];
            d.underload_shutdown_ctrl  = cmd[`HBFM_IN_UNDERLOAD_SHUTDOWN_CTRL];
            // Bridges still latched ignore this frame's enables until cleared
            d.bridge_on_bit       = cmd[`HBFM_IN_EN_HI:`HBFM_IN_EN_LO] & ~q.latched_off;
            d.bridge_polarity_bit = cmd[`HBFM_IN_CNF_HI:`HBFM_IN_CNF_LO] & ~q.latched_off;
            if (cmd[`HBFM_IN_SRR])
            begin
                d.oc_seen     = '0;
                d.ul_seen     = '0;
                // Thermal memory survives while the bridge is still too hot
                d.tsd_seen    = q.tsd_seen & tsd_s;
                d.latched_off = q.latched_off & q.tsd_seen & tsd_s;
            end
        end

        // Fault sets; flags are memorised even when the bridge stays on
        d.oc_seen     = d.oc_seen | oc_trip;
        d.ul_seen     = d.ul_seen | ul_hit;
        d.tsd_seen    = d.tsd_seen | tsd_s;
        d.latched_off = d.latched_off | latch_now;

        // Latch-off forgets the programming; lockouts below do not
        d.bridge_on_bit       = d.bridge_on_bit & ~latch_now;
        d.bridge_polarity_bit = d.bridge_polarity_bit & ~latch_now;

        // Output stage: lockout masks drive, programming untouched for recovery
        d.hs_on = d.bridge_on_bit & d.bridge_polarity_bit & {NB{!lockout}};
        d.ls_on = d.bridge_on_bit & ~d.bridge_polarity_bit & {NB{!lockout}};

        // Enable pin low acts as a full logic reset
        if (!en_s)
            d = '0;
    end

    // Single state register; power-on reset clears everything
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
            q <= '0;
        else
            q <= d;
    end

    // Drive pins come straight from the state register
    assign HIGH_SIDE_SWITCH_ON_O = q.hs_on;
    assign LOW_SIDE_SWITCH_ON_O  = q.ls_on;

endmodule

`default_nettype wire

//--- hbfm_props.sv
// Port checker of the half-bridge fault manager
`default_nettype none
`include "hbfm_map.svh"

module hbfm_props #(
    parameter int unsigned OC_DELAY_CYC = `HBFM_OC_DELAY_CYC
) (
    input wire logic                     CLK_I,
    input wire logic                     RESETN_I,
    input wire logic                     EN_I,
    input wire logic                     CS_N_I,
    input wire logic                     SO_O,
    input wire logic                     SO_OE_O,
    input wire logic                     MOTOR_SUPPLY_UV_I,
    input wire logic [`HBFM_BRIDGES-1:0] HIGH_SIDE_SWITCH_OC_I,
    input wire logic [`HBFM_BRIDGES-1:0] TEMP_SHUTDOWN_I,
    input wire logic [`HBFM_BRIDGES-1:0] HIGH_SIDE_SWITCH_ON_O,
    input wire logic [`HBFM_BRIDGES-1:0] LOW_SIDE_SWITCH_ON_O
);
    logic [15:0] oc_run_q;

    // Run length of over-current on a driven high side; margin covers sync and drive latency
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
            oc_run_q <= 16'h0000;
        else if ((HIGH_SIDE_SWITCH_OC_I & HIGH_SIDE_SWITCH_ON_O) != '0)
            oc_run_q <= oc_run_q + 16'h0001;
        else
            oc_run_q <= 16'h0000;
    end

    // All checks share the core clock and reset
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);

    a_no_shoot_through:
        assert property ((HIGH_SIDE_SWITCH_ON_O & LOW_SIDE_SWITCH_ON_O) == '0) else $error("both switches on");
    a_uv_lockout:
        assert property (MOTOR_SUPPLY_UV_I [*8] |-> (HIGH_SIDE_SWITCH_ON_O | LOW_SIDE_SWITCH_ON_O) == '0)
        else $error("drive during under-voltage");
    a_tsd_latch_off:
        assert property (($stable(TEMP_SHUTDOWN_I) && TEMP_SHUTDOWN_I != '0) [*8]
            |-> ((HIGH_SIDE_SWITCH_ON_O | LOW_SIDE_SWITCH_ON_O) & TEMP_SHUTDOWN_I) == '0)
        else $error("hot bridge still driven");
    a_oc_trip_bound:
        assert property (oc_run_q <= OC_DELAY_CYC + 12) else $error("over-current not tripped");
    a_en_clear:
        assert property ((!EN_I) [*8] |-> (HIGH_SIDE_SWITCH_ON_O | LOW_SIDE_SWITCH_ON_O) == '0)
        else $error("drive while enable low");
    a_oe_idle:
        assert property (CS_N_I [*8] |-> !SO_OE_O) else $error("serial out driven while idle");
    a_oe_active:
        assert property ((!CS_N_I && EN_I) [*8] |-> SO_OE_O) else $error("serial out not driven in frame");
    a_so_quiet:
        assert property (!SO_OE_O |-> !SO_O) else $error("serial out high while released");
endmodule

bind hbfm_top hbfm_props #(.OC_DELAY_CYC(OC_DELAY_CYC)) u_props (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
    .EN_I(EN_I), .CS_N_I(CS_N_I), .SO_O(SO_O), .SO_OE_O(SO_OE_O), .MOTOR_SUPPLY_UV_I(MOTOR_SUPPLY_UV_I),
    .HIGH_SIDE_SWITCH_OC_I(HIGH_SIDE_SWITCH_OC_I), .TEMP_SHUTDOWN_I(TEMP_SHUTDOWN_I),
    .HIGH_SIDE_SWITCH_ON_O(HIGH_SIDE_SWITCH_ON_O), .LOW_SIDE_SWITCH_ON_O(LOW_SIDE_SWITCH_ON_O));

`default_nettype wire

//--- hbfm_host.sv
// Serial host model: sends a command frame and collects the status word
`default_nettype none

module hbfm_host (
    input  wire logic   so_i,
    output logic        sclk_o,
    output logic        cs_n_o,
    output logic        si_o,
    output logic        done_o,
    output logic [16:0] rx_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int unsigned half_ns = 160;

    // Link clock idles low outside frames
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o   = 1'b0;
        done_o = 1'b0;
        rx_o   = '0;
    end

    // One frame of n bits; sampling mid-low leaves margin for the device's input sync
    task automatic xfer(input logic [23:0] cmd, input int n);
        int k;
        k = 0;
        cs_n_o = 1'b0;
        #(2 * half_ns);
        rx_o[16] = so_i; // Thermal latch shown before first rise
        si_o = cmd[n - 1];
        for (int i = n - 1; i >= 0; i--)
        begin
            #(half_ns / 2) sclk_o = 1'b1;
            #(half_ns) sclk_o = 1'b0;
            #(half_ns / 2);
            if (k < 16)
                rx_o[15 - k] = so_i;
            k++;
            if (i > 0)
                si_o = cmd[i - 1];
        end
        #(half_ns) cs_n_o = 1'b1;
        si_o = ~si_o; // Released line must not keep its last value
        done_o = 1'b1;
        #(half_ns) done_o = 1'b0;
    endtask
endmodule

`default_nettype wire

//--- hbfm_top_test.sv
// Bench of the half-bridge fault manager driven by the serial host model
`default_nettype none
`include "hbfm_map.svh"

module hbfm_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int OCD = 4;
    localparam int UNDERLOAD_FLAG = 16;
    localparam logic [5:0] ALL = 6'h3F;
    logic        clk = 1'b0, rst_n = 1'b0, en = 1'b1, ov_a = 1'b0, ov_b = 1'b0, uv = 1'b0;
    logic [5:0]  hs_oc = '0, ls_oc = '0, ul = '0, tw = '0, tsd = '0, hs, ls, e, p, m;
    logic        sclk, cs_n, si, so, so_oe, done;
    logic [16:0] rx;
    logic [16:0] exp_q[$];
    int          miscompares = 0, tests_run = 0, n;

    hbfm_top #(.OC_DELAY_CYC(OCD), .UL_DELAY_CYC(UNDERLOAD_FLAG)) dut (
        .CLK_I(clk), .RESETN_I(rst_n), .EN_I(en), .SCLK_I(sclk), .CS_N_I(cs_n), .SI_I(si),
        .SO_O(so), .SO_OE_O(so_oe), .MOTOR_SUPPLY_A_OV_I(ov_a), .MOTOR_SUPPLY_B_OV_I(ov_b),
        .MOTOR_SUPPLY_UV_I(uv), .HIGH_SIDE_SWITCH_OC_I(hs_oc), .LOW_SIDE_SWITCH_OC_I(ls_oc),
        .UNDERLOAD_CURRENT_LIMIT_I(ul), .TEMP_WARN_I(tw), .TEMP_SHUTDOWN_I(tsd),
        .HIGH_SIDE_SWITCH_ON_O(hs), .LOW_SIDE_SWITCH_ON_O(ls));
    hbfm_host host (.so_i(so), .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .done_o(done), .rx_o(rx));

    // 25 MHz core clock
    initial
        forever #20 clk = ~clk;

    task automatic check(input logic [16:0] seen, input logic [16:0] want);
        tests_run++;
        if (seen !== want)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic print_verdict;
        if (exp_q.size() != 0)
            miscompares++;
        $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic idle(input int c);
        repeat (c) @(negedge clk);
    endtask

    task automatic pins(input logic [5:0] eh, input logic [5:0] el);
        check({5'h00, hs, ls}, {5'h00, eh, el});
    endtask

    // Frame of n bits whose last 16 are {reset request, 0, under-load ctrl, enables, polarity, lockout}
    task automatic frx(input logic [2:0] f, input logic [5:0] en_b, input logic [5:0] pol, input int nb,
                       input logic [16:0] x);
        exp_q.push_back(x);
        host.xfer({8'hA5, f[2], 1'b0, f[1], en_b, pol, f[0]}, nb);
        idle(12);
    endtask

    task automatic fr(input logic [2:0] f, input logic [5:0] en_b, input logic [5:0] pol, input logic [16:0] x);
        frx(f, en_b, pol, 16, x);
    endtask

    // Each finished frame is matched against the oldest noted status word
    always @(posedge done)
        check(rx, exp_q.size() ? exp_q.pop_front() : 17'h1FFFF);

    // Hang guard
    initial
    begin
        #2000000;
        miscompares++;
        print_verdict();
    end

    // Main sequence
    initial
    begin
        void'($urandom(95));
        idle(16);
        rst_n = 1'b1;
        idle(10);
        for (int i = 0; i < 4; i++)
        begin
            e = 6'($urandom);
            p = 6'($urandom);
            fr(3'h1, e, p, 17'h00000);
            pins(e & p, e & ~p);
        end
        // Over-voltage with lockout set, then clear
        fr(3'h1, ALL, ALL, 17'h00000);
        ov_a = 1'b1;
        idle(10);
        pins(6'h00, 6'h00);
        fr(3'h0, ALL, ALL, 17'h04000);
        ov_a = 1'b0;
        ov_b = 1'b1;
        idle(10);
        pins(ALL, 6'h00);
        fr(3'h1, ALL, ALL, 17'h04000);
        ov_b = 1'b0;
        uv = 1'b1;
        idle(10);
        pins(6'h00, 6'h00);
        uv = 1'b0;
        tw = 6'h20;
        idle(10);
        pins(ALL, 6'h00);
        fr(3'h1, ALL, ALL, 17'h00001);
        tw = 6'h00;
        idle(10);
        // Over-current on a high side, then on a low side
        for (int s = 0; s < 2; s++)
        begin
            p = s ? 6'h00 : ALL;
            m = s ? 6'h20 : 6'h01;
            fr(3'h1, ALL, p, 17'h00000);
            hs_oc = s ? 6'h00 : m;
            ls_oc = s ? m : 6'h00;
            idle(20);
            hs_oc = 6'h00;
            ls_oc = 6'h00;
            pins(p & ~m, ~p & ~m);
            fr(3'h1, ALL, p, s ? 17'h08800 : 17'h08002);
            fr(3'h5, ALL, p, s ? 17'h08800 : 17'h08002);
            pins(p & ~m, ~p & ~m);
            fr(3'h1, ALL, p, 17'h00000);
            pins(p, ~p);
        end
        // Under-load with shutdown control clear only raises the flag
        ul = 6'h01;
        idle(UNDERLOAD_FLAG + 20);
        pins(6'h00, ALL);
        ul = 6'h00;
        fr(3'h3, ALL, 6'h00, 17'h02004);
        fr(3'h5, ALL, 6'h00, 17'h02004);
        fr(3'h3, ALL, 6'h00, 17'h00000);
        // Second under-load waits only the shared timer's remainder
        ul = 6'h02;
        idle(UNDERLOAD_FLAG / 2);
        ul = 6'h06;
        for (n = 0; n < 60 && ls[1] !== 1'b0; n++)
            @(negedge clk);
        if (n == 60)
        begin
            miscompares++;
            print_verdict();
        end
        idle(2);
        pins(6'h00, 6'h39);
        ul = 6'h00;
        idle(10);
        pins(6'h00, 6'h39);
        fr(3'h7, ALL, 6'h00, 17'h02050);
        fr(3'h1, ALL, 6'h00, 17'h00000);
        pins(6'h00, ALL);
        // Thermal shutdown holds while hot despite a reset request
        fr(3'h1, ALL, ALL, 17'h00000);
        tsd = 6'h08;
        idle(10);
        pins(6'h37, 6'h00);
        fr(3'h5, ALL, ALL, 17'h10180);
        fr(3'h1, ALL, ALL, 17'h10180);
        tsd = 6'h00;
        idle(10);
        fr(3'h5, ALL, ALL, 17'h10180);
        fr(3'h1, ALL, ALL, 17'h00000);
        pins(ALL, 6'h00);
        // Short frame is dropped, byte-extended frame is taken
        frx(3'h4, 6'h00, 6'h00, 15, 17'h00000);
        pins(ALL, 6'h00);
        frx(3'h1, 6'h15, 6'h2A, 24, 17'h00000);
        pins(6'h00, 6'h15);
        // Enable pin clears a latched over-current
        fr(3'h1, ALL, ALL, 17'h00000);
        hs_oc = 6'h01;
        idle(20);
        hs_oc = 6'h00;
        en = 1'b0;
        idle(10);
        pins(6'h00, 6'h00);
        en = 1'b1;
        idle(10);
        fr(3'h1, ALL, ALL, 17'h00000);
        pins(ALL, 6'h00);
        print_verdict();
    end
endmodule

`default_nettype wire
